// ==== include/udirq_pkg.sv ====
// Shared constants for the device interrupt status and DMA burst block
package udirq_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [11:0] UDIRQ_OFS_REASON = 12'h250; // DMA cause flags
    localparam logic [11:0] UDIRQ_OFS_STATUS = 12'h218; // Interrupt flags
    localparam logic [11:0] UDIRQ_OFS_BURST = 12'h264;  // Burst length
    localparam logic [11:0] UDIRQ_OFS_MASK = 12'h2F0;   // Interrupt mask
    localparam logic [11:0] UDIRQ_OFS_BUSCFG = 12'h2F4; // Bus width select

    // ************************************************************
    // Status register field positions
    // ************************************************************
    localparam int UDIRQ_BIT_BUS_RESET = 0;
    localparam int UDIRQ_BIT_SOF = 1;
    localparam int UDIRQ_BIT_PFRAME = 2;
    localparam int UDIRQ_BIT_SUSPEND = 3;
    localparam int UDIRQ_BIT_RESUME = 4;
    localparam int UDIRQ_BIT_HS = 5;
    localparam int UDIRQ_BIT_DMA = 6;
    localparam int UDIRQ_BIT_VBUS = 7;
    localparam int UDIRQ_BIT_SETUP = 8;
    localparam int UDIRQ_BIT_EP_BASE = 10;  // Endpoint n RX at base+2n
    localparam int UDIRQ_NUM_EP = 8;

    // ************************************************************
    // Reset values and implemented-bit masks
    // ************************************************************
    localparam logic [31:0] UDIRQ_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] UDIRQ_STATUS_VALID = 32'h03FF_FDFF;
    localparam logic [31:0] UDIRQ_KEEP_ON_BUS_RESET = 32'h0000_0001;
    localparam logic [31:0] UDIRQ_MASK_RESET = 32'h03FF_FDFF;
    localparam int UDIRQ_BURST_W = 13;
    localparam logic [12:0] UDIRQ_BURST_RESET = 13'h0004;
    localparam logic [15:0] UDIRQ_REASON_RESET = 16'h0000;
    localparam logic [15:0] UDIRQ_REASON_VALID = 16'h1500;
    localparam int UDIRQ_RSN_XFER_OK = 8;
    localparam int UDIRQ_RSN_INT_EOT = 10;
    localparam int UDIRQ_RSN_GDMA_STOP = 12;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int UDIRQ_CLK_PERIOD_NS = 25;
    localparam int UDIRQ_PF_FS_NS = 1000000;   // 1 ms full speed
    localparam int UDIRQ_PF_HS_NS = 125000;    // 125 us high speed
    localparam int UDIRQ_PF_FS_CYCLES = UDIRQ_PF_FS_NS / UDIRQ_CLK_PERIOD_NS;
    localparam int UDIRQ_PF_HS_CYCLES = UDIRQ_PF_HS_NS / UDIRQ_CLK_PERIOD_NS;

endpackage

// ==== core/udirq_pframe.sv ====
// Free-running pseudo frame tick generator
`timescale 1ns/10ps
module udirq_pframe
    import udirq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Period in clock cycles
    input wire logic [15:0] period,
    // One-cycle tick
    output logic tick
);

    logic [15:0] cnt_q; // Cycles since last tick
    logic tick_q;       // Registered tick
    logic wrap;         // Period reached

    // ************************************************************
    // Counter
    // ************************************************************
    // Compare with >= so a shorter period after a speed change
    // cannot make the counter run past its end
    assign wrap = (cnt_q >= (period - 16'h0001));

    // Counter runs unsynchronised to bus frames
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    assign tick = tick_q;

    pframe_spacing_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $stable(period) |-> (cnt_q < period))
        else $error("Pseudo frame counter ran past its period");

endmodule

// ==== core/udirq_burst.sv ====
// DMA request line with burst-length drop points
`timescale 1ns/10ps
module udirq_burst
    import udirq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration
    input wire logic [12:0] burst_len,
    input wire logic bus32,
    // DMA engine side
    input wire logic dma_active,
    input wire logic dma_cycle,
    // Request to the processor
    output logic dma_request_line
);

    logic [12:0] per_burst; // Bus cycles in one burst
    logic [12:0] cnt_q;     // Bus cycles done in this burst
    logic req_q;            // Registered request
    logic last;             // Final cycle of burst

    // ************************************************************
    // Burst size in bus cycles
    // ************************************************************
    // Length is in bytes; zero would never drop, so floor at one
    always_comb begin
        per_burst = bus32 ? {2'b00, burst_len[12:2]} :
                            {1'b0, burst_len[12:1]};
        if (per_burst == 13'h0000) begin
            per_burst = 13'h0001;
        end
    end

    assign last = dma_cycle && (cnt_q >= (per_burst - 13'h0001));

    // ************************************************************
    // Cycle counter and request
    // ************************************************************
    // Request drops for one clock after the last cycle of a burst
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 13'h0000;
            req_q <= 1'b0;
        end else begin
            req_q <= dma_active && !last;
            if (!dma_active) begin
                cnt_q <= 13'h0000;
            end else if (dma_cycle) begin
                cnt_q <= last ? 13'h0000 : cnt_q + 13'h0001;
            end
        end
    end

    assign dma_request_line = req_q;

    burst_drop16_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_cycle && !bus32 && burst_len == 13'h0002)
        |=> !dma_request_line)
        else $error("Request held after cycle in 16-bit burst of 2");

    burst_drop32_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_cycle && bus32 && burst_len == 13'h0004)
        |=> !dma_request_line)
        else $error("Request held after cycle in 32-bit burst of 4");

endmodule

// ==== core/udirq_top.sv ====
// Device interrupt status, DMA summary flag and burst length over APB
//
// What this block does
// - Burst length is thirteen bits, low bits
// - 16-bit, burst 2: request drops each cycle
// - 32-bit, burst 4: request drops each cycle
// - Hardware condition sets its status flag
// - Interrupt high while any unmasked flag set
// - Endpoint flags bits 10-25, setup bit 8
// - Bus-state flags bits 7-0 except DMA bit 6, reset bit 0
// - One summary flag for all DMA causes
// - Writing one clears flag, zero keeps
// - DMA reason change sets summary flag
// - Pseudo frame tick 1 ms/125 us flagged
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module udirq_top
    import udirq_pkg::*;
#(
    parameter int PF_FS_CYCLES = UDIRQ_PF_FS_CYCLES,
    parameter int PF_HS_CYCLES = UDIRQ_PF_HS_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Endpoint buffer events, one-cycle pulses
    input wire logic [7:0] ep_tx_event,
    input wire logic [7:0] ep_rx_event,
    input wire logic setup_event,
    // Bus state events, one-cycle pulses
    input wire logic vbus_rise_event,
    input wire logic hs_change_event,
    input wire logic resume_event,
    input wire logic suspend_event,
    input wire logic sof_event,
    input wire logic bus_reset_event,
    // Link speed level, high at high speed
    input wire logic hs_mode,
    // DMA engine causes, one-cycle pulses
    input wire logic dma_xfer_ok_event,
    input wire logic dma_int_eot_event,
    input wire logic dma_gdma_stop_event,
    // DMA engine handshake
    input wire logic dma_active,
    input wire logic dma_cycle,
    // Outputs to the processor
    output logic irq,
    output logic dma_request_line
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [31:0] status_q;     // Interrupt flags
    logic [31:0] status_d;     // Next interrupt flags
    logic [31:0] mask_q;       // Interrupt enables
    logic [12:0] burst_q;      // Burst length in bytes
    logic bus32_q;             // High for 32-bit data bus
    logic [15:0] reason_q;     // DMA cause flags
    logic [15:0] reason_d;     // Next DMA cause flags
    logic [15:0] reason_set;   // DMA causes this cycle
    logic [31:0] ev;           // Status events this cycle
    logic [31:0] status_clr;   // Status bits to clear
    logic [15:0] reason_clr;   // Reason bits to clear
    logic reason_chg;          // Reason content changes
    logic pf_tick;             // Pseudo frame tick
    logic [15:0] pf_period;    // Tick period in cycles
    logic irq_cause;           // Any enabled flag set
    logic irq_q;               // Registered interrupt
    logic [31:0] prdata_q;     // Read data
    logic pready_q;            // Access complete
    logic pslverr_q;           // Unmapped address
    logic acc_first;           // First access-phase cycle
    logic acc_done;            // Transfer completes now
    logic wr_en;               // Write takes effect
    logic mapped;              // Address decodes

    // Decode one register offset from the word address
    function automatic logic udirq_hit(input logic [11:0] addr,
                                       input logic [11:0] ofs);
        udirq_hit = (addr[11:2] == ofs[11:2]);
    endfunction

    // ************************************************************
    // APB handshake
    // ************************************************************
    // One wait state: read data is registered on the same edge that pready rises
    assign acc_first = psel && penable && !pready_q;
    assign acc_done = psel && penable && pready_q;
    assign wr_en = acc_done && pwrite;
    assign mapped = udirq_hit(paddr, UDIRQ_OFS_STATUS) ||
                    udirq_hit(paddr, UDIRQ_OFS_BURST) ||
                    udirq_hit(paddr, UDIRQ_OFS_REASON) ||
                    udirq_hit(paddr, UDIRQ_OFS_MASK) ||
                    udirq_hit(paddr, UDIRQ_OFS_BUSCFG);

    // Ready and error flags
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_first;
            pslverr_q <= acc_first && !mapped;
        end
    end

    // Read data mux; unmapped and reserved bits read zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc_first && !pwrite) begin
            if (udirq_hit(paddr, UDIRQ_OFS_STATUS)) begin
                prdata_q <= status_q;
            end else if (udirq_hit(paddr, UDIRQ_OFS_BURST)) begin
                prdata_q <= {19'h00000, burst_q};
            end else if (udirq_hit(paddr, UDIRQ_OFS_REASON)) begin
                prdata_q <= {16'h0000, reason_q};
            end else if (udirq_hit(paddr, UDIRQ_OFS_MASK)) begin
                prdata_q <= mask_q;
            end else if (udirq_hit(paddr, UDIRQ_OFS_BUSCFG)) begin
                prdata_q <= {31'h0000_0000, bus32_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Burst length returns to its reset value on a bus reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            burst_q <= UDIRQ_BURST_RESET;
        end else if (bus_reset_event) begin
            burst_q <= UDIRQ_BURST_RESET;
        end else if (wr_en && udirq_hit(paddr, UDIRQ_OFS_BURST)) begin
            burst_q <= pwdata[12:0];
        end
    end

    // Mask and bus width survive a bus reset; they are host setup
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_q <= UDIRQ_MASK_RESET;
            bus32_q <= 1'b0;
        end else if (wr_en) begin
            if (udirq_hit(paddr, UDIRQ_OFS_MASK)) begin
                mask_q <= pwdata & UDIRQ_STATUS_VALID;
            end
            if (udirq_hit(paddr, UDIRQ_OFS_BUSCFG)) begin
                bus32_q <= pwdata[0];
            end
        end
    end

    // ************************************************************
    // DMA reason flags
    // ************************************************************
    // Set beats clear so a cause arriving with its clear survives
    always_comb begin
        reason_set = 16'h0000;
        reason_set[UDIRQ_RSN_XFER_OK] = dma_xfer_ok_event;
        reason_set[UDIRQ_RSN_INT_EOT] = dma_int_eot_event;
        reason_set[UDIRQ_RSN_GDMA_STOP] = dma_gdma_stop_event;
        reason_clr = 16'h0000;
        if (wr_en && udirq_hit(paddr, UDIRQ_OFS_REASON)) begin
            reason_clr = pwdata[15:0];
        end
        if (bus_reset_event) begin
            reason_clr = 16'hFFFF;
        end
        reason_d = ((reason_q & ~reason_clr) | reason_set) &
                   UDIRQ_REASON_VALID;
    end

    // Any change, set or clear, raises the summary flag
    assign reason_chg = (reason_d != reason_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reason_q <= UDIRQ_REASON_RESET;
        end else begin
            reason_q <= reason_d;
        end
    end

    // ************************************************************
    // Interrupt status flags
    // ************************************************************
    // Gather events into their bit positions
    always_comb begin
        ev = 32'h0000_0000;
        ev[UDIRQ_BIT_BUS_RESET] = bus_reset_event;
        ev[UDIRQ_BIT_SOF] = sof_event;
        ev[UDIRQ_BIT_PFRAME] = pf_tick;
        ev[UDIRQ_BIT_SUSPEND] = suspend_event;
        ev[UDIRQ_BIT_RESUME] = resume_event;
        ev[UDIRQ_BIT_HS] = hs_change_event;
        ev[UDIRQ_BIT_DMA] = reason_chg;
        ev[UDIRQ_BIT_VBUS] = vbus_rise_event;
        ev[UDIRQ_BIT_SETUP] = setup_event;
        for (int n = 0; n < UDIRQ_NUM_EP; n++) begin
            ev[UDIRQ_BIT_EP_BASE + 2 * n] = ep_rx_event[n];
            ev[UDIRQ_BIT_EP_BASE + 2 * n + 1] = ep_tx_event[n];
        end
    end

    // Write-one clear and bus reset clear; new events win
    always_comb begin
        status_clr = 32'h0000_0000;
        if (wr_en && udirq_hit(paddr, UDIRQ_OFS_STATUS)) begin
            status_clr = pwdata;
        end
        if (bus_reset_event) begin
            status_clr = status_clr | ~UDIRQ_KEEP_ON_BUS_RESET;
        end
        status_d = ((status_q & ~status_clr) | ev) &
                   UDIRQ_STATUS_VALID;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q <= UDIRQ_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ************************************************************
    // Interrupt output
    // ************************************************************
    // Level output; the mask resets open so any flag asserts it
    assign irq_cause = |(status_q & mask_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_cause;
        end
    end

    // ************************************************************
    // Pseudo frame timer and DMA request
    // ************************************************************
    assign pf_period = hs_mode ? PF_HS_CYCLES[15:0] : PF_FS_CYCLES[15:0];

    udirq_pframe u_pframe (
        .sys_clk(sys_clk),
        .rst(rst),
        .period(pf_period),
        .tick(pf_tick)
    );

    // Software keeps burst lengths even per bus width
    udirq_burst u_burst (
        .sys_clk(sys_clk),
        .rst(rst),
        .burst_len(burst_q),
        .bus32(bus32_q),
        .dma_active(dma_active),
        .dma_cycle(dma_cycle),
        .dma_request_line(dma_request_line)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // ************************************************************
    // Checks
    // ************************************************************
    status_set_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ev != 32'h0000_0000) |=>
        ((status_q & $past(ev)) == ($past(ev) & UDIRQ_STATUS_VALID)))
        else $error("Event did not set its status flag");

    ep_map_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ep_tx_event[7] && ep_rx_event[0] && setup_event) |=>
        (status_q[25] && status_q[10] && status_q[8] && !status_q[9]))
        else $error("Endpoint or setup flag in wrong position");

    bus_reset_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        bus_reset_event |=> (status_q[0] &&
        ((status_q & ~$past(ev) & ~UDIRQ_KEEP_ON_BUS_RESET) == 32'h0)))
        else $error("Bus reset left stale flags or lost reset flag");

    w1c_clear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_en && udirq_hit(paddr, UDIRQ_OFS_STATUS) &&
         ev == 32'h0000_0000) |=>
        (status_q == ($past(status_q) & ~$past(pwdata))))
        else $error("Write-one clear wrong on status register");

    dma_summary_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (reason_q != $past(reason_q)) |-> status_q[UDIRQ_BIT_DMA])
        else $error("Reason change did not raise summary flag");

    irq_level_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        irq_cause |=> irq_q)
        else $error("Interrupt low while a flag is set");

    irq_drop_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!irq_cause ##1 !irq_cause) |-> !irq_q)
        else $error("Interrupt high with no flag set");

    burst_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_en && udirq_hit(paddr, UDIRQ_OFS_BURST) &&
         !bus_reset_event) |=> (burst_q == $past(pwdata[12:0])))
        else $error("Burst length not stored from write");

    pframe_flag_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        pf_tick |=> status_q[UDIRQ_BIT_PFRAME])
        else $error("Pseudo frame tick not flagged");

endmodule

// ==== tb/udirq_cpu.sv ====
// Processor model that drives the APB side of the interrupt block
`timescale 1ns/10ps
module udirq_cpu (
    // Clock
    input wire logic sys_clk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // ************************************************************
    // One transfer, held until pready is seen at a rising edge
    // ************************************************************
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output bit ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        ok = (n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data shows a changed value, never the stale word
        pwdata <= ~d;
    endtask
endmodule

// ==== tb/tb_dev_irq_status_and_dma_burst.sv ====
// Self-checking bench for the device interrupt and burst block
`timescale 1ns/10ps
module tb_dev_irq_status_and_dma_burst;
    import udirq_pkg::*;
    // ************************************************************
    // Stimulus and wiring
    // ************************************************************
    localparam int FS = 40; // Short full-speed frame period
    localparam int HS = 16; // Long enough to clear between ticks
    localparam logic [31:0] EV_OK = 32'h03FF_FDBA; // Directly raised
    localparam logic [31:0] NO_PF = 32'hFFFF_FFFB; // Tick runs free
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] ev_q = 32'h0; // Event pulses in status bit order
    logic [2:0] dma_ev_q = 3'h0; // DMA causes: ok, eot, stop
    logic hs_mode = 1'b0;
    logic dma_active = 1'b0;
    logic dma_cycle = 1'b0;
    logic [7:0] ep_rx, ep_tx;
    logic psel, penable, pwrite, pready, pslverr, irq, req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int failures = 0;
    int n_checks = 0;
    integer seed = 32'h2DC2;
    always #12.5 sys_clk = ~sys_clk;
    // Endpoint events come from the interleaved status positions
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            ep_rx[n] = ev_q[10 + 2 * n];
            ep_tx[n] = ev_q[11 + 2 * n];
        end
    end
    udirq_cpu cpu (.sys_clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    udirq_top #(.PF_FS_CYCLES(FS), .PF_HS_CYCLES(HS)) dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ep_tx_event(ep_tx), .ep_rx_event(ep_rx),
        .setup_event(ev_q[8]), .vbus_rise_event(ev_q[7]),
        .hs_change_event(ev_q[5]), .resume_event(ev_q[4]),
        .suspend_event(ev_q[3]), .sof_event(ev_q[1]),
        .bus_reset_event(ev_q[0]), .hs_mode(hs_mode),
        .dma_xfer_ok_event(dma_ev_q[0]),
        .dma_int_eot_event(dma_ev_q[1]),
        .dma_gdma_stop_event(dma_ev_q[2]),
        .dma_active(dma_active), .dma_cycle(dma_cycle),
        .irq(irq), .dma_request_line(req));
    // ************************************************************
    // Shared tasks and expectations
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        bit ok;
        cpu.xfer(w, a, d, r, e, ok);
        // A hung slave ends the run
        if (!ok) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic wait_irq(output time t);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (irq !== 1'b1 && n < 200);
        if (n >= 200) begin
            failures++;
            end_sim();
        end
        t = $time;
    endtask
    // Bus cycles per burst, at least one
    function automatic int per(input int b32, input int len);
        int p;
        p = (b32 != 0) ? len / 4 : len / 2;
        return (p < 1) ? 1 : p;
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] r, ev, cl;
        logic e;
        int p;
        time t[3];
        int lens[4];
        lens = '{2, 4, 8, 8};
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, UDIRQ_OFS_STATUS, 0, r, e);
        chk(r & NO_PF, 32'h0);
        bus(0, UDIRQ_OFS_BURST, 0, r, e);
        chk(r, 32'h4);
        bus(0, 12'h100, 0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        bus(1, UDIRQ_OFS_BURST, 32'h0000_1FFF, r, e);
        bus(0, UDIRQ_OFS_BURST, 0, r, e);
        chk(r, 32'h1FFF);
        // The free tick is kept off irq while other flags are tested
        bus(1, UDIRQ_OFS_MASK, UDIRQ_MASK_RESET & NO_PF, r, e);
        for (int i = 0; i < 6; i++) begin
            ev = (i == 0) ? EV_OK : ($random(seed) & EV_OK);
            cl = $random(seed) & ev;
            @(posedge sys_clk) ev_q <= ev;
            @(posedge sys_clk) ev_q <= 32'h0;
            bus(0, UDIRQ_OFS_STATUS, 0, r, e);
            chk(r & NO_PF, ev);
            chk({31'h0, irq}, {31'h0, ev != 0});
            bus(1, UDIRQ_OFS_STATUS, cl, r, e);
            bus(0, UDIRQ_OFS_STATUS, 0, r, e);
            chk(r & NO_PF, ev & ~cl);
            bus(1, UDIRQ_OFS_STATUS, ev & ~cl, r, e);
            repeat (2) @(posedge sys_clk);
            #1 chk({31'h0, irq}, 32'h0);
        end
        // Each DMA cause lands in the one summary flag
        for (int c = 0; c < 3; c++) begin
            @(posedge sys_clk) dma_ev_q <= 3'h1 << c;
            @(posedge sys_clk) dma_ev_q <= 3'h0;
            bus(0, UDIRQ_OFS_STATUS, 0, r, e);
            chk(r & NO_PF, 32'h40);
            bus(0, UDIRQ_OFS_REASON, 0, r, e);
            chk(r, 32'h100 << (2 * c));
            bus(1, UDIRQ_OFS_REASON, 32'h100 << (2 * c), r, e);
            bus(1, UDIRQ_OFS_STATUS, 32'h40, r, e);
            bus(0, UDIRQ_OFS_STATUS, 0, r, e);
            chk(r & NO_PF, 32'h0);
        end
        @(posedge sys_clk) ev_q <= EV_OK;
        @(posedge sys_clk) ev_q <= 32'h1;
        @(posedge sys_clk) ev_q <= 32'h0;
        bus(0, UDIRQ_OFS_STATUS, 0, r, e);
        chk(r & NO_PF, 32'h1);
        bus(0, UDIRQ_OFS_BURST, 0, r, e);
        chk(r, 32'h4);
        bus(1, UDIRQ_OFS_STATUS, 32'h1, r, e);
        // Request drops once after every P bus cycles
        for (int c = 0; c < 4; c++) begin
            p = per(c % 2, lens[c]);
            bus(1, UDIRQ_OFS_BUSCFG, c % 2, r, e);
            bus(1, UDIRQ_OFS_BURST, lens[c], r, e);
            @(posedge sys_clk) dma_active <= 1'b1;
            repeat (2) @(posedge sys_clk);
            for (int k = 1; k <= p; k++) begin
                @(posedge sys_clk) dma_cycle <= 1'b1;
                @(posedge sys_clk) dma_cycle <= 1'b0;
                #1 chk({31'h0, req}, {31'h0, k != p});
                @(posedge sys_clk);
                #1 chk({31'h0, req}, 32'h1);
            end
            @(posedge sys_clk) dma_active <= 1'b0;
        end
        // Only the tick reaches irq; time three rises per speed
        bus(1, UDIRQ_OFS_MASK, 32'h4, r, e);
        for (int m = 0; m < 2; m++) begin
            hs_mode <= m[0];
            for (int j = 0; j < 3; j++) begin
                bus(1, UDIRQ_OFS_STATUS, 32'h4, r, e);
                repeat (3) @(posedge sys_clk);
                wait_irq(t[j]);
            end
            chk(32'(t[2] - t[1]), 32'((m ? HS : FS) * 25));
        end
        end_sim();
    end
endmodule
